// *** hdl/pwrmc_pkg.sv ***
/*
 * Package for the power-mode control block: register addresses, bit
 * positions, reset values and the power state enumeration.
 * Assumes an 8-bit special-function register bus with byte addresses.
 */
package pwrmc_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] PWRMC_ADDR_POWER_CONTROL  = 8'h87;
	localparam logic [7:0] PWRMC_RST_POWER_CONTROL   = 8'h00;
	localparam logic [7:0] PWRMC_ADDR_INT_OSC_CTRL   = 8'hb2;
	localparam logic [7:0] PWRMC_RST_INT_OSC_CTRL    = 8'h00;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int PWRMC_BIT_IDLE    = 0;
	localparam int PWRMC_BIT_STOP    = 1;
	localparam int PWRMC_FLAGS_LSB   = 2;
	localparam int PWRMC_FLAGS_MSB   = 7;
	localparam int PWRMC_BIT_SUSPEND = 5;

	// Reset vector for the core after any reset
	localparam logic [15:0] PWRMC_RESET_VECTOR = 16'h0000;

	// ****************************************************************
	// Power states
	// ****************************************************************
	typedef enum logic [1:0] {
		PWRMC_RUN,
		PWRMC_IDLE,
		PWRMC_STOP,
		PWRMC_SUSPEND
	} pwrmc_state_e;
endpackage

// *** hdl/pwrmc_sync.sv ***
/*
 * Two-flop synchroniser for one level.
 * Assumes the input comes from outside the i_clk domain.
 */
`timescale 1ns/1ns
module pwrmc_sync (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Level in and out
	input  wire logic i_async,
	output logic      o_sync
);
	logic stage1;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule // pwrmc_sync

// *** hdl/pwrmc_top.sv ***
/*
 * Power-mode control: power control register, suspend bit of the internal
 * oscillator control register, and the idle/stop/suspend state machine.
 * Assumes a single-cycle SFR write/read port from the core, an
 * instruction-complete strobe, and an asynchronous USB resume level.
 */
// How it works
// [RQ1] Setting suspend bit stops HF oscillator and enters suspend after instruction completes.
// [RQ2] Suspend leaves all registers and memory untouched.
// [RQ3] Core keeps running in suspend unless clocked from the HF oscillator.
// [RQ4] USB resume or any reset ends suspend.
// [RQ5] Non-reset wake restarts HF oscillator; execution continues at next instruction.
// [RQ6] Wake configured as interrupt is serviced on waking.
// [RQ7] Reset ends suspend; normal reset sequence, fetch from 0x0000.
// [RQ8] Power control register at 0x87 on all pages, resets to zero.
// [RQ9] Bits 7:2 are software flags without hardware effect.
// [RQ10] Writing 1 to bit 1 enters stop mode, oscillator stopped.
// [RQ11] Writing 1 to bit 0 gates only the core clock.
// [RQ12] Stop and idle bits always read zero.
// [RQ13] Idle ends on enabled interrupt or reset.
// [RQ14] Stop ends only through reset.
// [RQ15] USB resume synchronised before it clears suspend.
`timescale 1ns/1ns
module pwrmc_top
	import pwrmc_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// SFR port
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	output logic             o_sfr_hit,
	// Core interface
	input  wire logic        i_instr_done,
	input  wire logic        i_irq_pending,
	input  wire logic        i_sysclk_is_hfosc,
	input  wire logic        i_resume_irq_en,
	// USB resume detector (asynchronous)
	input  wire logic        i_usb_resume,
	// Power control outputs
	output logic             o_hfosc_en,
	output logic             o_cpu_clk_en,
	output logic             o_periph_clk_en,
	output logic             o_resume_irq,
	output logic [15:0]      o_reset_vector,
	output logic [1:0]       o_state
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [5:0]   general_flags;
	logic [7:0]   internal_osc_control;
	logic         idle_req;
	logic         stop_req;
	logic         susp_req;
	logic         resume_sync;
	pwrmc_state_e state;
	pwrmc_state_e next_state;

	// Decode used for both read and write paths
	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic wr_pwr_ctl;
	logic wr_osc;
	assign wr_pwr_ctl = i_sfr_wr && is_addr(i_sfr_addr, PWRMC_ADDR_POWER_CONTROL); // [RQ8]
	assign wr_osc  = i_sfr_wr && is_addr(i_sfr_addr, PWRMC_ADDR_INT_OSC_CTRL);

	// Resume crosses in through two flops before anything looks at it
	pwrmc_sync u_resume_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (i_usb_resume),
		.o_sync  (resume_sync)
	); // [RQ15]

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Flags are plain storage; nothing else reads them
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			general_flags <= PWRMC_RST_POWER_CONTROL[PWRMC_FLAGS_MSB:PWRMC_FLAGS_LSB]; // [RQ8]
		end else if (wr_pwr_ctl) begin
			general_flags <= i_sfr_wdata[PWRMC_FLAGS_MSB:PWRMC_FLAGS_LSB]; // [RQ9]
		end
	end

	// Suspend bit self-clears on wake; other bits held across suspend
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			internal_osc_control <= PWRMC_RST_INT_OSC_CTRL; // [RQ7]
		end else if (wr_osc) begin
			internal_osc_control <= i_sfr_wdata;
		end else if (state == PWRMC_SUSPEND && resume_sync) begin
			internal_osc_control[PWRMC_BIT_SUSPEND] <= 1'b0; // [RQ4]
		end
	end

	// Mode requests wait for the setting instruction to complete
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idle_req <= 1'b0;
			stop_req <= 1'b0;
			susp_req <= 1'b0;
		end else begin
			if (wr_pwr_ctl && i_sfr_wdata[PWRMC_BIT_IDLE])
				idle_req <= 1'b1;
			else if (i_instr_done)
				idle_req <= 1'b0;
			if (wr_pwr_ctl && i_sfr_wdata[PWRMC_BIT_STOP])
				stop_req <= 1'b1;
			else if (i_instr_done)
				stop_req <= 1'b0;
			if (wr_osc && i_sfr_wdata[PWRMC_BIT_SUSPEND])
				susp_req <= 1'b1;
			else if (i_instr_done)
				susp_req <= 1'b0;
		end
	end

	// ****************************************************************
	// Power state machine
	// ****************************************************************
	// Stop has priority: it also halts the oscillator suspend would
	always_comb begin
		next_state = state;
		case (state)
			PWRMC_RUN: begin
				if (i_instr_done && stop_req)
					next_state = PWRMC_STOP; // [RQ10]
				else if (i_instr_done && idle_req)
					next_state = PWRMC_IDLE; // [RQ11]
				else if (i_instr_done && susp_req)
					next_state = PWRMC_SUSPEND; // [RQ1]
			end
			PWRMC_IDLE: begin
				if (i_irq_pending)
					next_state = PWRMC_RUN; // [RQ13]
			end
			PWRMC_STOP: begin
				next_state = PWRMC_STOP; // [RQ14]
			end
			PWRMC_SUSPEND: begin
				if (resume_sync)
					next_state = PWRMC_RUN; // [RQ4] [RQ5]
			end
			default: next_state = PWRMC_RUN;
		endcase
	end

	// Only reset leaves stop; reset returns every mode to run
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			state <= PWRMC_RUN; // [RQ7]
		else
			state <= next_state;
	end

	// Wake interrupt pulse when resume ends suspend
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_resume_irq <= 1'b0;
		else
			o_resume_irq <= (state == PWRMC_SUSPEND) && resume_sync && i_resume_irq_en; // [RQ6]
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Core runs in suspend only on a clock other than the HF oscillator
	assign o_hfosc_en      = (state == PWRMC_RUN) || (state == PWRMC_IDLE); // [RQ1] [RQ5]
	assign o_cpu_clk_en    = (state == PWRMC_RUN) ||
	                         (state == PWRMC_SUSPEND && !i_sysclk_is_hfosc); // [RQ3] [RQ11]
	assign o_periph_clk_en = (state != PWRMC_STOP); // [RQ10] [RQ11]
	assign o_reset_vector  = PWRMC_RESET_VECTOR; // [RQ7]
	assign o_state         = state;

	// Mode bits read zero; mode changes touch no storage except the suspend bit cleared on wake
	assign o_sfr_hit   = is_addr(i_sfr_addr, PWRMC_ADDR_POWER_CONTROL) ||
	                     is_addr(i_sfr_addr, PWRMC_ADDR_INT_OSC_CTRL);
	always_comb begin
		o_sfr_rdata = 8'h00;
		if (is_addr(i_sfr_addr, PWRMC_ADDR_POWER_CONTROL))
			o_sfr_rdata = {general_flags, 2'b00}; // [RQ12] [RQ2]
		else if (is_addr(i_sfr_addr, PWRMC_ADDR_INT_OSC_CTRL))
			o_sfr_rdata = internal_osc_control;
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_pwr_ctl_read_zero;
		@(posedge i_clk) disable iff (!i_rst_n)
		is_addr(i_sfr_addr, PWRMC_ADDR_POWER_CONTROL) |-> o_sfr_rdata[1:0] == 2'b00;
	endproperty
	a_pwr_ctl_read_zero: assert property (p_pwr_ctl_read_zero) else $error("mode bits read nonzero"); // [RQ12]

	property p_flags_store;
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_pwr_ctl |=> general_flags == $past(i_sfr_wdata[PWRMC_FLAGS_MSB:PWRMC_FLAGS_LSB]);
	endproperty
	a_flags_store: assert property (p_flags_store) else $error("flags not stored"); // [RQ9]

	property p_susp_entry;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == PWRMC_RUN && susp_req && i_instr_done && !stop_req && !idle_req)
			|=> state == PWRMC_SUSPEND && !o_hfosc_en;
	endproperty
	a_susp_entry: assert property (p_susp_entry) else $error("suspend not entered"); // [RQ1]

	property p_susp_wake;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == PWRMC_SUSPEND && resume_sync) |=> state == PWRMC_RUN && o_hfosc_en;
	endproperty
	a_susp_wake: assert property (p_susp_wake) else $error("resume did not wake"); // [RQ4]

	property p_susp_cpu;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == PWRMC_SUSPEND && !i_sysclk_is_hfosc) |-> o_cpu_clk_en;
	endproperty
	a_susp_cpu: assert property (p_susp_cpu) else $error("cpu halted in suspend"); // [RQ3]

	property p_stop_hold;
		@(posedge i_clk) disable iff (!i_rst_n)
		state == PWRMC_STOP |=> state == PWRMC_STOP && !o_periph_clk_en;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset"); // [RQ14]

	property p_idle_clk;
		@(posedge i_clk) disable iff (!i_rst_n)
		state == PWRMC_IDLE |-> !o_cpu_clk_en && o_periph_clk_en;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clock gating wrong"); // [RQ11]

	property p_idle_wake;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == PWRMC_IDLE && i_irq_pending) |=> state == PWRMC_RUN;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("interrupt did not end idle"); // [RQ13]

	property p_wake_irq;
		@(posedge i_clk) disable iff (!i_rst_n)
		(state == PWRMC_SUSPEND && resume_sync && i_resume_irq_en) |=> o_resume_irq;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake interrupt missing"); // [RQ6]

	c_suspend: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		state == PWRMC_SUSPEND ##1 state == PWRMC_RUN);
	c_idle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		state == PWRMC_IDLE ##1 state == PWRMC_RUN);
	c_stop: cover property (@(posedge i_clk) disable iff (!i_rst_n) state == PWRMC_STOP);
endmodule // pwrmc_top

// *** verification/pwrmc_usb_host.sv ***
/*
 * USB host stand-in: drives resume signalling as one level.
 * Assumes the bench pulses i_wake; the line idles low between wakes.
 */
`timescale 1ns/1ns
module pwrmc_usb_host #(
	parameter int RESUME_NS = 150
) (
	// Command from the bench
	input  wire logic i_wake,
	// Resume level to the detector
	output logic      o_resume
);
	// Off-grid start so the level lands unrelated to the core clock
	initial o_resume = 1'b0;
	always @(posedge i_wake) begin
		#7 o_resume = 1'b1;
		#RESUME_NS o_resume = 1'b0; // Short, so a later suspend is not woken at once
	end
endmodule // pwrmc_usb_host

// *** verification/power_mode_control_test.sv ***
/*
 * Self-checking bench for pwrmc_top: register map, idle, stop and suspend.
 * Assumes inputs change at falling edges and the host model drives resume.
 */
`timescale 1ns/1ns
module power_mode_control_test;
	import pwrmc_pkg::*;
	logic        i_clk, i_rst_n, i_sfr_wr, i_instr_done, i_irq_pending;
	logic        i_sysclk_is_hfosc, i_resume_irq_en, i_usb_resume, wake;
	logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
	logic        o_sfr_hit, o_hfosc_en, o_cpu_clk_en, o_periph_clk_en, o_resume_irq;
	logic [15:0] o_reset_vector;
	logic [1:0]  o_state;
	int          err_count, checked, irq_cnt;
	localparam logic [7:0] PC = PWRMC_ADDR_POWER_CONTROL;
	localparam logic [7:0] OC = PWRMC_ADDR_INT_OSC_CTRL;

	// ****************************************************************
	// Clock, instances, probes
	// ****************************************************************
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	pwrmc_top u_pwrmc_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
		.i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
		.i_instr_done(i_instr_done), .i_irq_pending(i_irq_pending), .i_sysclk_is_hfosc(i_sysclk_is_hfosc),
		.i_resume_irq_en(i_resume_irq_en), .i_usb_resume(i_usb_resume), .o_hfosc_en(o_hfosc_en),
		.o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_resume_irq(o_resume_irq),
		.o_reset_vector(o_reset_vector), .o_state(o_state));
	pwrmc_usb_host u_pwrmc_usb_host (.i_wake(wake), .o_resume(i_usb_resume));
	// Count wake interrupt pulses at the settled falling edge, one per cycle high
	always @(negedge i_clk) if (o_resume_irq === 1'b1) irq_cnt++;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(negedge i_clk);
		i_sfr_wr = 1'b0;
	endtask
	// Read data is combinational; settle, then realign to the falling edge
	task rd(input logic [7:0] a, input logic [7:0] e);
		i_sfr_addr = a;
		#1 chk("rdata", o_sfr_rdata, e);
		@(negedge i_clk);
	endtask
	// Mode requests are taken when an instruction completes
	task done;
		i_instr_done = 1'b1;
		@(negedge i_clk);
		i_instr_done = 1'b0;
	endtask
	task outs(input logic [1:0] st, input logic hf, input logic cpu);
		chk("state", o_state, st);
		chk("hfosc_en", o_hfosc_en, hf);
		chk("cpu_clk_en", o_cpu_clk_en, cpu);
	endtask
	task rst;
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		@(negedge i_clk);
	endtask
	// Resume must pass the synchroniser before the state may move
	task wake_wait(input logic [1:0] st);
		wake = 1'b1;
		@(negedge i_clk);
		wake = 1'b0;
		chk("state", o_state, st);
		repeat (6) if (o_state !== PWRMC_RUN) @(negedge i_clk);
		@(negedge i_clk);
	endtask
	task report_and_stop;
		if (err_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{i_rst_n, i_sfr_wr, i_instr_done, i_irq_pending, i_resume_irq_en, wake} = '0;
		{i_sysclk_is_hfosc, i_sfr_addr, i_sfr_wdata} = '0;
		{err_count, checked, irq_cnt} = '0;
		repeat (20) @(negedge i_clk);
		i_rst_n = 1'b1;
		@(negedge i_clk);
		// Reset values and refusal of other addresses
		rd(PC, 8'h00);
		chk("hit", o_sfr_hit, 1'b1);
		rd(OC, 8'h00);
		wr(8'h88, 8'hff);
		rd(8'h88, 8'h00);
		chk("hit", o_sfr_hit, 1'b0);
		chk("vector", o_reset_vector, 16'h0000);
		outs(PWRMC_RUN, 1'b1, 1'b1);
		// Flags hold; mode bits read zero; idle until interrupt
		wr(PC, 8'ha8);
		rd(PC, 8'ha8);
		wr(PC, 8'h55);
		rd(PC, 8'h54);
		outs(PWRMC_RUN, 1'b1, 1'b1);
		done;
		repeat (3) @(negedge i_clk);
		outs(PWRMC_IDLE, 1'b1, 1'b0);
		chk("periph_clk_en", o_periph_clk_en, 1'b1);
		i_irq_pending = 1'b1;
		@(negedge i_clk);
		i_irq_pending = 1'b0;
		outs(PWRMC_RUN, 1'b1, 1'b1);
		// Suspend on another clock, USB wake with interrupt
		i_resume_irq_en = 1'b1;
		wr(OC, 8'h20);
		rd(OC, 8'h20);
		done;
		outs(PWRMC_SUSPEND, 1'b0, 1'b1);
		rd(PC, 8'h54);
		wake_wait(PWRMC_SUSPEND);
		outs(PWRMC_RUN, 1'b1, 1'b1);
		chk("irq", irq_cnt, 1);
		rd(OC, 8'h00);
		// Suspend on the HF clock without interrupt, then ended by reset
		i_resume_irq_en = 1'b0;
		i_sysclk_is_hfosc = 1'b1;
		wr(OC, 8'h20);
		done;
		outs(PWRMC_SUSPEND, 1'b0, 1'b0);
		wake_wait(PWRMC_SUSPEND);
		outs(PWRMC_RUN, 1'b1, 1'b1);
		chk("irq", irq_cnt, 1);
		wr(OC, 8'h20);
		done;
		rst;
		outs(PWRMC_RUN, 1'b1, 1'b1);
		rd(OC, 8'h00);
		// Stop ignores interrupts and USB wake, only reset ends it
		wr(PC, 8'h02);
		done;
		outs(PWRMC_STOP, 1'b0, 1'b0);
		chk("periph_clk_en", o_periph_clk_en, 1'b0);
		i_irq_pending = 1'b1;
		wake_wait(PWRMC_STOP);
		i_irq_pending = 1'b0;
		outs(PWRMC_STOP, 1'b0, 1'b0);
		rd(PC, 8'h00);
		rst;
		outs(PWRMC_RUN, 1'b1, 1'b1);
		report_and_stop;
	end

	// Watchdog at 3000 cycles, well beyond the roughly 70 cycles the tests need
	initial begin
		#(3000 * 50);
		err_count++;
		report_and_stop;
	end
endmodule // power_mode_control_test
